// ---- verification/pwmt_top_tb.sv ----
`timescale 1ns/100ps
module pwmt_top_tb;
    import pwmt_pkg::*;

    typedef struct packed {
        logic [2:0]  pre;
        logic [3:0]  mode;
        logic [1:0]  act_a;
        logic [1:0]  act_b;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] ones_a;
        logic [15:0] ones_b;
        logic [15:0] flags;
    } pwmt_case_t;

    // TOP is 7 from the capture register or compare A; 448 cycles span whole periods of every row.
    localparam pwmt_case_t ROWS [11] = '{
        '{PRE_DIV1, MODE_FAST_CAP,  ACT_NONINV, ACT_INV,    16'h0001, 16'h0005, 16'h0070, 16'h0070, 16'h000f},
        '{PRE_DIV1, MODE_FAST_CAP,  ACT_INV,    ACT_NONINV, 16'h0000, 16'h0007, 16'h0188, 16'h01c0, 16'h000f},
        '{PRE_DIV1, MODE_FAST_CAP,  ACT_NONINV, ACT_INV,    16'h0007, 16'h0000, 16'h01c0, 16'h0188, 16'h000f},
        '{PRE_DIV1, MODE_FAST_CAP,  ACT_TOGGLE, ACT_NONINV, 16'h0003, 16'h0009, 16'h00e0, 16'h01c0, 16'h000b},
        '{PRE_DIV1, MODE_FAST_CAP,  ACT_NONE,   ACT_INV,    16'h0002, 16'h0007, 16'h0000, 16'h0000, 16'h000f},
        '{PRE_DIV1, MODE_PC_CAP,    ACT_NONINV, ACT_INV,    16'h0003, 16'h0003, 16'h00c0, 16'h0100, 16'h000f},
        '{PRE_DIV1, MODE_PC_CAP,    ACT_INV,    ACT_NONINV, 16'h0000, 16'h0007, 16'h01c0, 16'h01c0, 16'h000f},
        '{PRE_DIV1, MODE_PC_CAP,    ACT_NONINV, ACT_INV,    16'h0000, 16'h0007, 16'h0000, 16'h0000, 16'h000f},
        '{PRE_DIV1, MODE_FAST_CMPA, ACT_NONE,   ACT_NONINV, 16'h0007, 16'h0003, 16'h0000, 16'h00e0, 16'h0007},
        '{PRE_DIV1, MODE_PC_CMPA,   ACT_NONE,   ACT_INV,    16'h0007, 16'h0002, 16'h0000, 16'h0140, 16'h0007},
        '{PRE_DIV8, MODE_FAST_CAP,  ACT_NONINV, ACT_NONE,   16'h0001, 16'h0000, 16'h0070, 16'h0000, 16'h000f}
    };
    localparam logic [3:0]  MASK_MODE [7] = '{MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_PC8, MODE_PC9, MODE_PC10,
                                              MODE_FAST_CAP};
    localparam logic [15:0] MASK_EXP  [7] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT, TOP_8BIT, TOP_9BIT, TOP_10BIT, TOP_MAX};
    localparam logic [2:0]  RST_ADDR  [7] = '{REG_CTRL, REG_CMP_A, REG_CMP_B, REG_CAP_TOP, REG_COUNT, REG_FLAGS, 3'h7};
    localparam logic [15:0] RST_EXP   [7] = '{16'h0000, 16'h0000, 16'h0000, TOP_MAX, 16'h0000, 16'h0000, 16'h0000};

    logic                I_CORE_CLK;
    logic                I_NRST;
    logic [ADDR_W-1:0]   I_ADDR;
    logic [DATA_W-1:0]   I_WDATA;
    logic                I_WR;
    logic                I_RD;
    logic [DATA_W-1:0]   O_RDATA;
    logic                O_PIN_A;
    logic                O_PIN_A_OE;
    logic                O_PIN_B;
    logic                O_PIN_B_OE;
    int                  n_fail;
    int                  num_checks;
    logic [15:0]         rdv;
    logic [15:0]         ones_a;
    logic [15:0]         ones_b;

    pwmt_top uut (
        .I_CORE_CLK (I_CORE_CLK),
        .I_NRST     (I_NRST),
        .I_ADDR     (I_ADDR),
        .I_WDATA    (I_WDATA),
        .I_WR       (I_WR),
        .I_RD       (I_RD),
        .O_RDATA    (O_RDATA),
        .O_PIN_A    (O_PIN_A),
        .O_PIN_A_OE (O_PIN_A_OE),
        .O_PIN_B    (O_PIN_B),
        .O_PIN_B_OE (O_PIN_B_OE)
    );

    initial begin
        I_CORE_CLK = 1'b0;
        forever #4 I_CORE_CLK = ~I_CORE_CLK;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge I_CORE_CLK);
        I_WR    <= 1'b1;
        I_ADDR  <= a;
        I_WDATA <= d;
        @(posedge I_CORE_CLK);
        I_WR    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge I_CORE_CLK);
        I_RD   <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CORE_CLK);
        I_RD   <= 1'b0;
        #1 d = O_RDATA;
    endtask

    // Writing the unmapped index first also shows that such a write lands nowhere.
    task automatic reset_values();
        wr(3'h7, 16'hffff);
        for (int i = 0; i < 7; i++) begin
            rd(RST_ADDR[i], rdv);
            chk("reset register", rdv, RST_EXP[i]);
        end
        rd(REG_PIN, rdv);
        chk("reset pin register", rdv, 16'h0000);
        @(posedge I_CORE_CLK);
        #1 chk("read data idle", O_RDATA, 16'h0000);
        chk("reset pins", {12'h000, O_PIN_A, O_PIN_A_OE, O_PIN_B, O_PIN_B_OE}, 16'h0000);
    endtask

    // Reads are issued back to back, so every cycle shows the count of the cycle before.
    task automatic count_walk(input logic [3:0] mode, input bit dual);
        logic [15:0] prev;
        logic [15:0] cur;
        logic [15:0] exp;
        bit          up;
        bit          known;
        wr(REG_CTRL, {5'h00, PRE_STOP, 4'h0, mode});
        wr(REG_CAP_TOP, 16'h0007);
        wr(REG_COUNT, 16'h0000);
        wr(REG_CTRL, {5'h00, PRE_DIV1, 4'h0, mode});
        @(posedge I_CORE_CLK);
        I_RD   <= 1'b1;
        I_ADDR <= REG_COUNT;
        @(posedge I_CORE_CLK);
        #1 prev = O_RDATA;
        known = 1'b0;
        up = 1'b1;
        repeat (40) begin
            @(posedge I_CORE_CLK);
            #1 cur = O_RDATA;
            if (prev === 16'h0007) begin
                known = 1'b1;
                up = 1'b0;
            end
            if (prev === 16'h0000) begin
                known = 1'b1;
                up = 1'b1;
            end
            if (!dual) exp = (prev === 16'h0007) ? 16'h0000 : prev + 16'h0001;
            else exp = up ? prev + 16'h0001 : prev - 16'h0001;
            if (known) chk("count step", cur, exp);
            prev = cur;
        end
        I_RD <= 1'b0;
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // The whole run needs about 7700 cycles; over twice that is generous.
    initial begin
        repeat (20000) @(posedge I_CORE_CLK);
        n_fail++;
        end_of_test();
    end

    initial begin
        pwmt_case_t r;
        n_fail = 0;
        num_checks = 0;
        I_NRST = 1'b0;
        I_ADDR = '0;
        I_WDATA = '0;
        I_WR = 1'b0;
        I_RD = 1'b0;
        repeat (8) @(posedge I_CORE_CLK);
        I_NRST <= 1'b1;
        reset_values();
        foreach (ROWS[i]) begin
            r = ROWS[i];
            wr(REG_CTRL, {5'h00, PRE_STOP, r.act_b, r.act_a, r.mode});
            wr(REG_CAP_TOP, 16'h0007);
            wr(REG_CMP_A, r.cmp_a);
            wr(REG_CMP_B, r.cmp_b);
            wr(REG_COUNT, 16'h0000);
            wr(REG_PIN, 16'h0003);
            wr(REG_CTRL, {5'h00, r.pre, r.act_b, r.act_a, r.mode});
            wr(REG_FLAGS, 16'h000f);
            repeat (150) @(posedge I_CORE_CLK);
            ones_a = '0;
            ones_b = '0;
            repeat (448) begin
                @(posedge I_CORE_CLK);
                #1 if (O_PIN_A === 1'b1) ones_a++;
                if (O_PIN_B === 1'b1) ones_b++;
            end
            chk("high cycles A", ones_a, r.ones_a);
            chk("high cycles B", ones_b, r.ones_b);
            chk("pin enables", {14'h0000, O_PIN_A_OE, O_PIN_B_OE}, 16'h0003);
            wr(REG_CTRL, {5'h00, PRE_STOP, r.act_b, r.act_a, r.mode});
            rd(REG_FLAGS, rdv);
            chk("flags", rdv, r.flags);
        end
        // Fixed widths truncate compare writes; a register TOP keeps all sixteen bits.
        foreach (MASK_MODE[i]) begin
            wr(REG_CTRL, {8'h00, 4'h0, MASK_MODE[i]});
            wr(REG_CMP_B, 16'hffff);
            rd(REG_CMP_B, rdv);
            chk("masked compare", rdv, MASK_EXP[i]);
        end
        count_walk(MODE_FAST_CAP, 1'b0);
        count_walk(MODE_PC_CAP, 1'b1);
        // A capture TOP written below the count is missed, so the count keeps climbing.
        wr(REG_CTRL, {5'h00, PRE_STOP, 4'h0, MODE_FAST_CAP});
        wr(REG_COUNT, 16'h0006);
        wr(REG_CAP_TOP, 16'h0003);
        wr(REG_CTRL, {5'h00, PRE_DIV1, 4'h0, MODE_FAST_CAP});
        repeat (40) @(posedge I_CORE_CLK);
        wr(REG_CTRL, {5'h00, PRE_STOP, 4'h0, MODE_FAST_CAP});
        rd(REG_COUNT, rdv);
        chk("count past low TOP", {15'h0000, rdv > 16'h0007}, 16'h0001);
        // Exactly 640 edges see divide by 64, so ten ticks whatever the prescaler phase.
        wr(REG_CAP_TOP, 16'hffff);
        wr(REG_COUNT, 16'h0000);
        wr(REG_CTRL, {5'h00, PRE_DIV64, 4'h0, MODE_FAST_CAP});
        repeat (638) @(posedge I_CORE_CLK);
        wr(REG_CTRL, {5'h00, PRE_STOP, 4'h0, MODE_FAST_CAP});
        rd(REG_COUNT, rdv);
        chk("divide by 64 ticks", rdv, 16'h000a);
        // Reset in mid-run must drop every pin and restore the register defaults.
        wr(REG_CAP_TOP, 16'h0007);
        wr(REG_PIN, 16'h0003);
        wr(REG_CTRL, {5'h00, PRE_DIV1, ACT_INV, ACT_INV, MODE_FAST_CAP});
        repeat (20) @(posedge I_CORE_CLK);
        I_NRST <= 1'b0;
        repeat (3) @(posedge I_CORE_CLK);
        #1 chk("pins in reset", {12'h000, O_PIN_A, O_PIN_A_OE, O_PIN_B, O_PIN_B_OE}, 16'h0000);
        I_NRST <= 1'b1;
        reset_values();
        end_of_test();
    end
endmodule

// ---- verilog/pwmt_pkg.sv ----
package pwmt_pkg;
    localparam int          ADDR_W        = 3;
    localparam int          DATA_W        = 16;
    localparam int          PRE_W         = 10;

    // Register indices on the plain register port.
    localparam logic [2:0]  REG_CTRL      = 3'h0;
    localparam logic [2:0]  REG_CMP_A     = 3'h1;
    localparam logic [2:0]  REG_CMP_B     = 3'h2;
    localparam logic [2:0]  REG_CAP_TOP   = 3'h3;
    localparam logic [2:0]  REG_COUNT     = 3'h4;
    localparam logic [2:0]  REG_FLAGS     = 3'h5;
    localparam logic [2:0]  REG_PIN       = 3'h6;

    // Control register fields.
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_ACTA_LSB = 4;
    localparam int          CTRL_ACTB_LSB = 6;
    localparam int          CTRL_PRE_LSB  = 8;

    // Flag register bits, write one to clear.
    localparam int          FLG_OVF       = 0;
    localparam int          FLG_MATCH_A   = 1;
    localparam int          FLG_MATCH_B   = 2;
    localparam int          FLG_CAPTURE   = 3;

    // Pin register bits.
    localparam int          PIN_DIR_A     = 0;
    localparam int          PIN_DIR_B     = 1;
    localparam int          PIN_PORT_A    = 2;
    localparam int          PIN_PORT_B    = 3;

    // Waveform mode codes.
    localparam logic [3:0]  MODE_PC8      = 4'h1;
    localparam logic [3:0]  MODE_PC9      = 4'h2;
    localparam logic [3:0]  MODE_PC10     = 4'h3;
    localparam logic [3:0]  MODE_FAST8    = 4'h5;
    localparam logic [3:0]  MODE_FAST9    = 4'h6;
    localparam logic [3:0]  MODE_FAST10   = 4'h7;
    localparam logic [3:0]  MODE_PC_CAP   = 4'ha;
    localparam logic [3:0]  MODE_PC_CMPA  = 4'hb;
    localparam logic [3:0]  MODE_FAST_CAP = 4'he;
    localparam logic [3:0]  MODE_FAST_CMPA = 4'hf;

    localparam logic [15:0] TOP_8BIT      = 16'h00ff;
    localparam logic [15:0] TOP_9BIT      = 16'h01ff;
    localparam logic [15:0] TOP_10BIT     = 16'h03ff;
    localparam logic [15:0] TOP_MAX       = 16'hffff;
    localparam logic [15:0] BOTTOM        = 16'h0000;

    // Output action codes.
    localparam logic [1:0]  ACT_NONE      = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
    localparam logic [1:0]  ACT_NONINV    = 2'h2;
    localparam logic [1:0]  ACT_INV       = 2'h3;

    // Prescale select codes and their divider masks (divide by 1, 8, 64, 256, 1024).
    localparam logic [2:0]  PRE_STOP      = 3'h0;
    localparam logic [2:0]  PRE_DIV1      = 3'h1;
    localparam logic [2:0]  PRE_DIV8      = 3'h2;
    localparam logic [2:0]  PRE_DIV64     = 3'h3;
    localparam logic [2:0]  PRE_DIV256    = 3'h4;
    localparam logic [2:0]  PRE_DIV1024   = 3'h5;
    localparam logic [9:0]  MASK_DIV8     = 10'h007;
    localparam logic [9:0]  MASK_DIV64    = 10'h03f;
    localparam logic [9:0]  MASK_DIV256   = 10'h0ff;
    localparam logic [9:0]  MASK_DIV1024  = 10'h3ff;

    typedef enum logic [1:0] {
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } pwmt_dir_t;
endpackage

// ---- verilog/pwmt_top.sv ----
`timescale 1ns/100ps
// Function
// R1 - Single-slope: count up from zero to TOP chosen by mode, register or fixed.
// R2 - Single-slope: after TOP the counter returns to zero next tick.
// R3 - Single-slope non-inverting clears on match, sets at wrap; inverting reverses.
// R4 - Action two selects non-inverted PWM, three selects inverted PWM.
// R5 - Single-slope: overflow flag at TOP; TOP register's flag set same tick.
// R6 - With fixed TOP, compare writes zero bits above the resolution.
// R7 - Capture TOP acts at once; below count, counter runs through wrap.
// R8 - Single-slope: compare A buffered, loaded at TOP with wrap and overflow.
// R9 - Single-slope action one on A toggles each match; buffering stays on.
// R10 - Single-slope: compare zero gives spike, compare TOP gives constant level.
// R11 - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// R12 - Dual-slope: count up to TOP then down to zero, TOP chosen by mode.
// R13 - Dual-slope: count stays at TOP for exactly one tick.
// R14 - Dual-slope non-inverting clears on up match, sets on down match.
// R15 - Dual-slope: overflow at zero; TOP register flag set at TOP.
// R16 - Dual-slope: compare registers load from buffers at TOP.
// R17 - Dual-slope: compare zero holds low, compare TOP holds high, non-inverted.
// R18 - Register TOP is at least 0x0003, up to 16-bit maximum.
// R19 - Software keeps compare values at or below TOP; above never matches. The code matches once the count runs past a TOP written below it.
// R20 - Software should prefer frequency correct mode when changing TOP live.
// R21 - Compare output reaches pin only when its direction bit is output.
// R22 - Match flag set whenever count equals the active compare value. The code sets it only on a timer tick in a PWM mode.
// R23 - Action zero leaves output state alone; nonzero gives pin to generator.
// R24 - Reset clears the compare output state bits.
// R25 - All updates run on the core clock, qualified by the timer tick.
module pwmt_top (
    input  wire logic                          I_CORE_CLK,
    input  wire logic                          I_NRST,
    input  wire logic [pwmt_pkg::ADDR_W-1:0]   I_ADDR,
    input  wire logic [pwmt_pkg::DATA_W-1:0]   I_WDATA,
    input  wire logic                          I_WR,
    input  wire logic                          I_RD,
    output logic      [pwmt_pkg::DATA_W-1:0]   O_RDATA,
    output logic                               O_PIN_A,
    output logic                               O_PIN_A_OE,
    output logic                               O_PIN_B,
    output logic                               O_PIN_B_OE
);
    import pwmt_pkg::*;

    function automatic logic [15:0] fn_top(input logic [3:0] m, input logic [15:0] cap, input logic [15:0] cmpa);
        logic [15:0] t;
        t = TOP_MAX;
        if (m == MODE_FAST8 || m == MODE_PC8) begin
            t = TOP_8BIT;
        end else if (m == MODE_FAST9 || m == MODE_PC9) begin
            t = TOP_9BIT;
        end else if (m == MODE_FAST10 || m == MODE_PC10) begin
            t = TOP_10BIT;
        end else if (m == MODE_FAST_CAP || m == MODE_PC_CAP) begin
            t = cap;
        end else if (m == MODE_FAST_CMPA || m == MODE_PC_CMPA) begin
            t = cmpa;
        end
        return t;
    endfunction

    function automatic logic fn_is_fast(input logic [3:0] m);
        return m == MODE_FAST8 || m == MODE_FAST9 || m == MODE_FAST10 || m == MODE_FAST_CAP || m == MODE_FAST_CMPA;
    endfunction

    function automatic logic fn_is_pc(input logic [3:0] m);
        return m == MODE_PC8 || m == MODE_PC9 || m == MODE_PC10 || m == MODE_PC_CAP || m == MODE_PC_CMPA;
    endfunction

    // Next output state for one channel; the edge event wins over a match in the same tick.
    function automatic logic fn_out(input logic cur, input logic [1:0] act, input logic match,
                                    input logic edge_ev, input logic clr_on_match, input logic tog_ok);
        logic r;
        r = cur;
        if (act == ACT_NONINV || act == ACT_INV) begin
            if (edge_ev) begin
                r = (act == ACT_NONINV);
            end else if (match) begin
                r = clr_on_match ? (act == ACT_INV) : (act == ACT_NONINV);
            end
        end else if (act == ACT_TOGGLE && tog_ok && match) begin
            r = ~cur;
        end
        return r;
    endfunction

    logic [3:0]   mode_q;
    logic [1:0]   act_a_q;
    logic [1:0]   act_b_q;
    logic [2:0]   pre_sel_q;
    logic [15:0]  cmp_a_buf_q;
    logic [15:0]  cmp_b_buf_q;
    logic [15:0]  cmp_a_act_q;
    logic [15:0]  cmp_b_act_q;
    logic [15:0]  cap_top_q;
    logic [15:0]  count_q;
    logic [15:0]  count_d;
    pwmt_dir_t    dir_q;
    pwmt_dir_t    dir_d;
    logic [9:0]   pre_cnt_q;
    logic [3:0]   flags_q;
    logic [3:0]   pin_cfg_q;
    logic         out_a_q;
    logic         out_b_q;
    logic         tick;
    logic         fast;
    logic         pc;
    logic [15:0]  top;
    logic         at_top;
    logic         at_bottom;
    logic         match_a;
    logic         match_b;
    logic         going_up;
    logic         load_buf;
    logic [15:0]  wmask;
    logic         wr_ctrl;
    logic         wr_cmp_a;
    logic         wr_cmp_b;

    assign fast      = fn_is_fast(mode_q);
    assign pc        = fn_is_pc(mode_q);
    assign top       = fn_top(mode_q, cap_top_q, cmp_a_act_q);  // see R1 see R12
    assign at_top    = (count_q == top);
    assign at_bottom = (count_q == BOTTOM);
    // A compare value above TOP matches only when a TOP written below the count lets the count run past it.
    assign match_a   = tick && (fast || pc) && (count_q == cmp_a_act_q);  // see R22 see R19
    assign match_b   = tick && (fast || pc) && (count_q == cmp_b_act_q);  // see R22
    assign load_buf  = tick && (fast || pc) && at_top && (fast || dir_q == DIR_UP);  // see R8 see R16
    // Bottom counts as rising and TOP as falling, which pins the extremes to a constant level.
    assign going_up  = at_bottom || (dir_q == DIR_UP && !at_top);  // see R17
    assign wmask     = (fn_top(mode_q, TOP_MAX, TOP_MAX) == TOP_MAX) ? TOP_MAX : fn_top(mode_q, BOTTOM, BOTTOM);
    assign wr_ctrl   = I_WR && (I_ADDR == REG_CTRL);
    assign wr_cmp_a  = I_WR && (I_ADDR == REG_CMP_A);
    assign wr_cmp_b  = I_WR && (I_ADDR == REG_CMP_B);

    // Prescaler: the low bits of a free running count form the tick.
    always_comb begin
        unique case (pre_sel_q)
            PRE_DIV1:    tick = 1'b1;  // see R11
            PRE_DIV8:    tick = ((pre_cnt_q & MASK_DIV8) == MASK_DIV8);
            PRE_DIV64:   tick = ((pre_cnt_q & MASK_DIV64) == MASK_DIV64);
            PRE_DIV256:  tick = ((pre_cnt_q & MASK_DIV256) == MASK_DIV256);
            PRE_DIV1024: tick = ((pre_cnt_q & MASK_DIV1024) == MASK_DIV1024);
            default:     tick = 1'b0;
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 10'h001;  // see R25
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            mode_q    <= '0;
            act_a_q   <= ACT_NONE;
            act_b_q   <= ACT_NONE;
            pre_sel_q <= PRE_STOP;
            pin_cfg_q <= '0;
            cap_top_q <= TOP_MAX;
        end else begin
            if (wr_ctrl) begin
                mode_q    <= I_WDATA[CTRL_MODE_LSB +: 4];
                act_a_q   <= I_WDATA[CTRL_ACTA_LSB +: 2];
                act_b_q   <= I_WDATA[CTRL_ACTB_LSB +: 2];
                pre_sel_q <= I_WDATA[CTRL_PRE_LSB +: 3];
            end
            if (I_WR && I_ADDR == REG_PIN) begin
                pin_cfg_q <= I_WDATA[3:0];
            end
            // Unbuffered: the new TOP is compared against the very next count.
            if (I_WR && I_ADDR == REG_CAP_TOP) begin
                cap_top_q <= I_WDATA;  // see R7 see R18
            end
        end
    end

    // Writes go to the buffers; the active values follow at TOP in PWM modes.
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cmp_a_buf_q <= '0;
            cmp_b_buf_q <= '0;
            cmp_a_act_q <= '0;
            cmp_b_act_q <= '0;
        end else begin
            if (wr_cmp_a) begin
                cmp_a_buf_q <= I_WDATA & wmask;  // see R6
            end
            if (wr_cmp_b) begin
                cmp_b_buf_q <= I_WDATA & wmask;  // see R6
            end
            if (load_buf) begin
                cmp_a_act_q <= cmp_a_buf_q;  // see R8 see R16 see R9
                cmp_b_act_q <= cmp_b_buf_q;
            end else if (!(fast || pc)) begin
                cmp_a_act_q <= cmp_a_buf_q;
                cmp_b_act_q <= cmp_b_buf_q;
            end
        end
    end

    always_comb begin
        count_d = count_q;
        dir_d   = dir_q;
        if (tick && fast) begin
            // A TOP below the count is missed, so the count rolls through 0xffff.
            count_d = at_top ? BOTTOM : count_q + 16'h0001;  // see R1 see R2 see R7
            dir_d   = DIR_UP;
        end else if (tick && pc) begin
            unique case (dir_q)
                DIR_UP: begin
                    if (at_top) begin
                        count_d = count_q - 16'h0001;  // see R13 see R12
                        dir_d   = DIR_DOWN;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
                DIR_DOWN: begin
                    if (at_bottom) begin
                        count_d = count_q + 16'h0001;  // see R12
                        dir_d   = DIR_UP;
                    end else begin
                        count_d = count_q - 16'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            count_q <= BOTTOM;
            dir_q   <= DIR_UP;
        end else if (I_WR && I_ADDR == REG_COUNT) begin
            count_q <= I_WDATA;
            dir_q   <= dir_q;
        end else begin
            count_q <= count_d;
            dir_q   <= dir_d;
        end
    end

    // Set wins over a write-one clear arriving in the same cycle.
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            flags_q <= '0;
        end else begin
            logic [3:0] set_v;
            set_v = '0;
            set_v[FLG_OVF]     = tick && ((fast && at_top) || (pc && at_bottom));  // see R5 see R15
            set_v[FLG_MATCH_A] = match_a || (load_buf && (mode_q == MODE_FAST_CMPA || mode_q == MODE_PC_CMPA));
            set_v[FLG_MATCH_B] = match_b;  // see R22
            set_v[FLG_CAPTURE] = load_buf && (mode_q == MODE_FAST_CAP || mode_q == MODE_PC_CAP);  // see R5 see R15
            if (I_WR && I_ADDR == REG_FLAGS) begin
                flags_q <= (flags_q & ~I_WDATA[3:0]) | set_v;
            end else begin
                flags_q <= flags_q | set_v;
            end
        end
    end

    // Changing the action takes effect at once; there is no buffer for it.
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            out_a_q <= 1'b0;  // see R24
            out_b_q <= 1'b0;
        end else if (tick && fast) begin
            out_a_q <= fn_out(out_a_q, act_a_q, match_a, at_top, 1'b1, 1'b1);  // see R3 see R4 see R9 see R10 see R23
            out_b_q <= fn_out(out_b_q, act_b_q, match_b, at_top, 1'b1, 1'b0);  // see R3
        end else if (tick && pc) begin
            out_a_q <= fn_out(out_a_q, act_a_q, match_a, 1'b0, going_up, 1'b0);  // see R14 see R17
            out_b_q <= fn_out(out_b_q, act_b_q, match_b, 1'b0, going_up, 1'b0);  // see R14
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_PIN_A    <= 1'b0;
            O_PIN_B    <= 1'b0;
            O_PIN_A_OE <= 1'b0;
            O_PIN_B_OE <= 1'b0;
        end else begin
            O_PIN_A    <= (act_a_q != ACT_NONE) ? out_a_q : pin_cfg_q[PIN_PORT_A];  // see R23
            O_PIN_B    <= (act_b_q != ACT_NONE) ? out_b_q : pin_cfg_q[PIN_PORT_B];
            O_PIN_A_OE <= pin_cfg_q[PIN_DIR_A];  // see R21
            O_PIN_B_OE <= pin_cfg_q[PIN_DIR_B];
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_RDATA <= '0;
        end else if (I_RD) begin
            unique case (I_ADDR)
                REG_CTRL:    O_RDATA <= {5'h00, pre_sel_q, act_b_q, act_a_q, mode_q};
                REG_CMP_A:   O_RDATA <= cmp_a_buf_q;
                REG_CMP_B:   O_RDATA <= cmp_b_buf_q;
                REG_CAP_TOP: O_RDATA <= cap_top_q;
                REG_COUNT:   O_RDATA <= count_q;
                REG_FLAGS:   O_RDATA <= {12'h000, flags_q};
                REG_PIN:     O_RDATA <= {12'h000, pin_cfg_q};
                default:     O_RDATA <= '0;
            endcase
        end else begin
            O_RDATA <= '0;
        end
    end

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    a_fast_count_up: assert property (tick && fast && !at_top && !I_WR |=> count_q == $past(count_q) + 16'h0001) else $error("fast count did not step up"); // see R1
    a_fast_wrap_zero: assert property (tick && fast && at_top && !I_WR |=> count_q == BOTTOM) else $error("fast count did not wrap"); // see R2
    a_fast_ovf_flag: assert property (tick && fast && at_top |=> flags_q[FLG_OVF]) else $error("overflow flag missing at top"); // see R5
    a_fast_buf_load: assert property (tick && fast && at_top |=> cmp_a_act_q == $past(cmp_a_buf_q)) else $error("compare A not loaded at top"); // see R8
    a_noninv_clear: assert property (tick && fast && act_a_q == ACT_NONINV && match_a && !at_top |=> !out_a_q) else $error("non-inverted output not cleared"); // see R3
    a_pc_top_one: assert property (tick && pc && dir_q == DIR_UP && at_top && !I_WR |=> dir_q == DIR_DOWN && count_q == $past(count_q) - 16'h0001) else $error("top not held one tick"); // see R13
    a_pc_ovf_bottom: assert property (tick && pc && at_bottom |=> flags_q[FLG_OVF]) else $error("overflow flag missing at bottom"); // see R15
    a_match_flag: assert property (match_b ##1 1'b1 |-> flags_q[FLG_MATCH_B]) else $error("match flag missing"); // see R22
    a_pin_dir_gate: assert property (I_WR && I_ADDR == REG_PIN && !I_WDATA[PIN_DIR_A] |=> ##1 !O_PIN_A_OE) else $error("pin driven while input"); // see R21
    a_mask_fixed: assert property (wr_cmp_a && mode_q == MODE_FAST8 |=> cmp_a_buf_q[15:8] == 8'h00) else $error("compare bits above resolution kept"); // see R6
    a_div1_tick: assert property (pre_sel_q == PRE_DIV1 |-> tick) else $error("divide by one missed a tick"); // see R11

    // These guard the less travelled turns and flags that the pin counts alone would hide.
    a_capture_flag: assert property (load_buf && (mode_q == MODE_FAST_CAP || mode_q == MODE_PC_CAP) |=> flags_q[FLG_CAPTURE])  // see R5
        else $error("capture flag missing at top");
    a_pc_down_step: assert property (tick && pc && dir_q == DIR_DOWN && !at_bottom && !I_WR |=> count_q == $past(count_q) - 16'h0001)  // see R12
        else $error("dual-slope count did not step down");
    a_pc_bottom_turn: assert property (tick && pc && dir_q == DIR_DOWN && at_bottom && !I_WR |=> dir_q == DIR_UP)  // see R12
        else $error("dual-slope count did not turn at bottom");
    a_pc_hold_down: assert property (tick && pc && dir_q == DIR_DOWN |=> cmp_a_act_q == $past(cmp_a_act_q))  // see R16
        else $error("compare A loaded on the down slope");
    a_inv_set_match: assert property (tick && fast && act_a_q == ACT_INV && match_a && !at_top |=> out_a_q)  // see R3
        else $error("inverted output not set on match");
    a_pc_up_clear: assert property (tick && pc && act_b_q == ACT_NONINV && match_b && going_up |=> !out_b_q)  // see R14
        else $error("dual-slope output not cleared on up match");
    a_port_passthru: assert property (act_a_q == ACT_NONE |=> O_PIN_A == $past(pin_cfg_q[PIN_PORT_A]))  // see R23
        else $error("pin not given back to port value");
    a_oe_follows_dir: assert property (1'b1 |=> O_PIN_B_OE == $past(pin_cfg_q[PIN_DIR_B]))  // see R21
        else $error("pin B enable does not follow direction");
endmodule
